// ==== net_cfg_pkg.sv ====
package net_cfg_pkg;

	// register byte addresses as printed
	localparam logic [6:0] PAGE_SIZE_SELECT_OFF = 7'h2f;
	localparam logic [6:0] RATE_PRESCALER_SELECT_OFF = 7'h30;
	localparam logic [6:0] TIME_PHASE_DIFFERENCE_OFF = 7'h32;
	localparam logic [6:0] STRAP_PIN_SNAPSHOT_OFF = 7'h34;
	localparam logic [6:0] ERROR_CAUSE_INFO_OFF = 7'h3a;

	// reset values
	localparam logic [1:0] PAGE_SIZE_RST = 2'h0;
	localparam logic [2:0] RATE_PRESCALER_RST = 3'h0;
	localparam logic [15:0] PHASE_DIFF_RST = 16'h8000;
	localparam logic [15:0] ERROR_INFO_RST = 16'h0000;
	localparam logic [15:0] CLOCK_MASTER_PHASE = 16'h0000;

	// field positions in the error cause register
	localparam int RECONFIGURATION_FLAG_CODE_LSB = 12;
	localparam int LCC_PORT_BIT = 11;
	localparam int LCC_CODE_LSB = 8;
	localparam int RX_CODE_LSB = 5;
	localparam int RX_SID_LSB = 0;

	// field positions in the phase register
	localparam int PHASE_DIR_BIT = 15;

	// strap snapshot positions
	localparam int PIN_SWAP_HI = 15;
	localparam int PIN_WIDE_HI = 14;
	localparam int PIN_TEST_BIT = 8;
	localparam int PIN_SWAP_LO = 7;
	localparam int PIN_WIDE_LO = 6;

	// reconfiguration causes
	localparam logic [2:0] RECONFIGURATION_FLAG_NOISE_AFTER_TOKEN = 3'h0;
	localparam logic [2:0] RECONFIGURATION_FLAG_LAST_DEFINED = 3'h5;

	// packet receive error codes
	localparam logic [2:0] RX_ERR_FRAME = 3'h0;
	localparam logic [2:0] RX_ERR_COUNT_PTR = 3'h1;
	localparam logic [2:0] RX_ERR_CRC = 3'h2;
	localparam logic [2:0] RX_ERR_LENGTH = 3'h3;
	localparam logic [2:0] RX_ERR_DEST = 3'h4;
	localparam logic [2:0] RX_ERR_LCC_STOP = 3'h5;
	localparam logic [2:0] RX_ERR_PAGE = 3'h6;
	localparam logic [2:0] RX_ERR_MULTI = 3'h7;

	// byte lane encodings
	localparam logic [1:0] LANE_LOW = 2'h1;
	localparam logic [1:0] LANE_HIGH = 2'h2;

	// auto soft reset sequencer states
	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_ASSERT = 2'b01,
		SR_RELEASE = 2'b10
	} soft_rst_e;

endpackage

// ==== strap_sync.sv ====
`timescale 1ns/1ps

// two flip-flop synchroniser for a group of pin levels
module strap_sync #(
	parameter int WIDTH = 1
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_pins
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage is read only by the second stage
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (i_ce) begin
			meta_q <= i_pins;
			sync_q <= meta_q;
		end
	end

	assign o_pins = sync_q;

endmodule

// ==== net_config_error_status_regs.sv ====
`timescale 1ns/1ps
// Function
// - init select 1 uses written page size; 0 reads back strap pins
// - init select 1 uses written prescaler; 0 reads back prescaler straps
// - page size or prescaler change while online fires self-releasing soft reset
// - phase bit 15 is direction: 0 ahead, 1 behind, resets to 1
// - phase bits 14:0 hold absolute time difference, reset zero
// - clock master reads the whole phase register as zero
// - 8-bit host reads even byte first, which latches odd byte
// - strap snapshot register shows live levels of setup straps
// - snapshot bit 8 is 1 when any test pin is low
// - swap and wide straps appear in bits 15,14 and 7,6
// - error bits 14:12 hold reconfig cause, cleared by clear flags or soft reset
// - reconfig causes 000 to 101 as defined, 11x undefined
// - with tolerance select 0 only cause 000 triggers reconfiguration
// - error bit 11 names correction port, stays 0 when hub disabled
// - correction info captured on flag set, cleared by flag write or soft reset
// - three-bit correction code names decoder state and substitution
// - error bits 7:5 hold packet receive error code
// - receive code defaults 000, cleared by flag write or soft reset
// - error bits 4:0 capture source node id of the failing packet
// - captured source id cleared by flag write or soft reset
module net_config_error_status_regs
	import net_cfg_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// host register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_byte_en,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	// core control levels
	input wire logic i_init_source_select,
	input wire logic i_transmit_online_enable,
	input wire logic i_clock_master_node,
	input wire logic i_ack_nak_tolerance_select,
	input wire logic i_hub_enable,
	input wire logic i_soft_rst_req,
	// time engine phase
	input wire logic i_phase_direction_flag,
	input wire logic [14:0] i_phase_difference_magnitude,
	// reconfiguration event
	input wire logic i_reconfig_event,
	input wire logic [2:0] i_reconfig_cause_code,
	input wire logic i_clear_flags_cmd,
	// line code correction event
	input wire logic i_line_code_corrected_set,
	input wire logic i_line_code_port,
	input wire logic [2:0] i_line_code_correction_info,
	input wire logic i_line_code_corrected_clr,
	// packet receive error event
	input wire logic i_rx_error_set,
	input wire logic [6:0] i_rx_error_causes,
	input wire logic [4:0] i_rx_error_source_id,
	input wire logic i_rx_error_flag_clr,
	// strap pins
	input wire logic [1:0] i_page_size_strap,
	input wire logic [2:0] i_rate_prescaler_strap,
	input wire logic i_byte_swap_strap_n,
	input wire logic i_wide_bus_strap,
	input wire logic i_op_mode_strap_n,
	input wire logic i_hub_on_strap_n,
	input wire logic i_ext_wr_strap_n,
	input wire logic i_ext_rd_strap_n,
	input wire logic i_line_code_bypass_strap_n,
	input wire logic i_diag_strap_n,
	input wire logic i_transmit_online_enable_polarity_strap,
	input wire logic [1:0] i_time_prescale_strap,
	input wire logic [1:0] i_warn_prescale_strap,
	input wire logic [3:0] i_test_select_pins_n,
	input wire logic i_test_enable_pin_n,
	// configuration and event outputs
	output logic [1:0] o_page_size_field,
	output logic [2:0] o_rate_prescaler_field,
	output logic o_soft_rst,
	output logic o_reconfig_trigger
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check

	if (ADDR_W < 6) begin : g_bad_addr
		$error("address width too small for the register map");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations

	localparam int PIN_W = 23;

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_s;
	logic [1:0] ps_strap_s;
	logic [2:0] ckp_strap_s;
	logic swap_s;
	logic wide_s;
	logic [10:0] misc_s;
	logic [4:0] test_s;

	logic [1:0] page_wr_q;
	logic [2:0] rate_wr_q;
	logic [1:0] page_act;
	logic [2:0] rate_act;
	logic [1:0] page_q;
	logic [2:0] rate_q;
	logic cfg_changed;
	soft_rst_e sr_state_q;
	soft_rst_e sr_state_d;
	logic soft_rst_q;
	logic local_clr;

	logic [15:0] phase_q;
	logic [7:0] phase_hi_q;
	logic [15:0] pin_info;

	logic [2:0] reconfiguration_flag_code_q;
	logic lcc_port_q;
	logic [2:0] lcc_code_q;
	logic [2:0] rx_code_q;
	logic [4:0] rx_sid_q;
	logic reconfiguration_flag_accept;
	logic reconfig_trigger_q;
	logic [15:0] err_info;
	logic [15:0] rdata_q;

	logic wr_page;
	logic wr_rate;
	logic rd_phase;

	////////////////////////////////////////////////////////////////////////////
	// functions

	// word compare of a host address against a register offset
	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [6:0] off);
		logic [6:0] a7;
		a7 = 7'(addr);
		return a7[6:1] == off[6:1];
	endfunction

	// receive error encoding, several of length/lcc/page collapse to 111
	function automatic logic [2:0] rx_encode(input logic [6:0] c);
		logic [1:0] n;
		logic [2:0] code;
		n = 2'(c[3]) + 2'(c[5]) + 2'(c[6]);
		code = RX_ERR_FRAME;
		if (n > 2'h1) begin
			code = RX_ERR_MULTI;
		end else if (c[0]) begin
			code = RX_ERR_FRAME;
		end else if (c[1]) begin
			code = RX_ERR_COUNT_PTR;
		end else if (c[2]) begin
			code = RX_ERR_CRC;
		end else if (c[3]) begin
			code = RX_ERR_LENGTH;
		end else if (c[4]) begin
			code = RX_ERR_DEST;
		end else if (c[5]) begin
			code = RX_ERR_LCC_STOP;
		end else if (c[6]) begin
			code = RX_ERR_PAGE;
		end
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// strap pin synchronisation

	// all straps are asynchronous pins
	assign pins_raw = {i_page_size_strap, i_rate_prescaler_strap, i_byte_swap_strap_n, i_wide_bus_strap,
		i_op_mode_strap_n, i_hub_on_strap_n, i_ext_wr_strap_n, i_ext_rd_strap_n,
		i_line_code_bypass_strap_n, i_diag_strap_n, i_transmit_online_enable_polarity_strap,
		i_time_prescale_strap, i_warn_prescale_strap, i_test_select_pins_n, i_test_enable_pin_n};

	strap_sync #(
		.WIDTH(PIN_W)
	) u_strap_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_pins(pins_raw),
		.o_pins(pins_s)
	);

	// unpack synchronised straps
	assign ps_strap_s = pins_s[22:21];
	assign ckp_strap_s = pins_s[20:18];
	assign swap_s = pins_s[17];
	assign wide_s = pins_s[16];
	assign misc_s = pins_s[15:5];
	assign test_s = pins_s[4:0];

	////////////////////////////////////////////////////////////////////////////
	// host decode

	assign wr_page = i_wr && i_byte_en[0] && hits(i_addr, PAGE_SIZE_SELECT_OFF);
	assign wr_rate = i_wr && i_byte_en[0] && hits(i_addr, RATE_PRESCALER_SELECT_OFF);
	assign rd_phase = i_rd && hits(i_addr, TIME_PHASE_DIFFERENCE_OFF);

	////////////////////////////////////////////////////////////////////////////
	// page size and prescaler

	// written values, only the low lane holds bits
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			page_wr_q <= PAGE_SIZE_RST;
			rate_wr_q <= RATE_PRESCALER_RST;
		end else if (i_ce) begin
			if (wr_page) begin
				page_wr_q <= i_wdata[1:0];
			end
			if (wr_rate) begin
				rate_wr_q <= i_wdata[2:0];
			end
		end
	end

	// source select between register and straps
	assign page_act = i_init_source_select ? page_wr_q : ps_strap_s;
	assign rate_act = i_init_source_select ? rate_wr_q : ckp_strap_s;

	// active values drive the core
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			page_q <= PAGE_SIZE_RST;
			rate_q <= RATE_PRESCALER_RST;
		end else if (i_ce) begin
			page_q <= page_act;
			rate_q <= rate_act;
		end
	end

	assign o_page_size_field = page_q;
	assign o_rate_prescaler_field = rate_q;

	////////////////////////////////////////////////////////////////////////////
	// automatic soft reset

	// the host should go offline first; if it does not, reset ourselves
	assign cfg_changed = i_transmit_online_enable && ((page_act != page_q) || (rate_act != rate_q));

	// next state: one cycle asserted, then released without host action
	always_comb begin
		sr_state_d = sr_state_q;
		case (sr_state_q)
			SR_IDLE: begin
				if (cfg_changed) begin
					sr_state_d = SR_ASSERT;
				end
			end
			SR_ASSERT: begin
				sr_state_d = SR_RELEASE;
			end
			SR_RELEASE: begin
				sr_state_d = SR_IDLE;
			end
			default: begin
				sr_state_d = SR_IDLE;
			end
		endcase
	end

	// state register and registered soft reset output
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sr_state_q <= SR_IDLE;
			soft_rst_q <= 1'b0;
		end else if (i_ce) begin
			sr_state_q <= sr_state_d;
			soft_rst_q <= (sr_state_d == SR_ASSERT) || i_soft_rst_req;
		end
	end

	assign o_soft_rst = soft_rst_q;
	assign local_clr = soft_rst_q;

	////////////////////////////////////////////////////////////////////////////
	// phase difference

	// clock master reads zero, others follow the time engine
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || local_clr) begin
			phase_q <= PHASE_DIFF_RST;
		end else if (i_ce) begin
			if (i_clock_master_node) begin
				phase_q <= CLOCK_MASTER_PHASE;
			end else begin
				phase_q <= {i_phase_direction_flag, i_phase_difference_magnitude};
			end
		end
	end

	// even byte read freezes the odd byte for a coherent pair
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			phase_hi_q <= PHASE_DIFF_RST[15:8];
		end else if (i_ce) begin
			if (rd_phase && (i_byte_en == LANE_LOW)) begin
				phase_hi_q <= phase_q[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// strap snapshot

	// live straps, swap and wide duplicated on both lanes
	always_comb begin
		pin_info = '0;
		pin_info[PIN_SWAP_HI] = swap_s;
		pin_info[PIN_WIDE_HI] = wide_s;
		pin_info[13:9] = misc_s[10:6];
		pin_info[PIN_TEST_BIT] = ~&test_s;
		pin_info[PIN_SWAP_LO] = swap_s;
		pin_info[PIN_WIDE_LO] = wide_s;
		pin_info[5:0] = misc_s[5:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// error cause capture

	// tolerance select 0 lets only the noise cause through
	assign reconfiguration_flag_accept = i_reconfig_event && (i_reconfig_cause_code <= RECONFIGURATION_FLAG_LAST_DEFINED)
		&& (i_ack_nak_tolerance_select || (i_reconfig_cause_code == RECONFIGURATION_FLAG_NOISE_AFTER_TOKEN));

	// reconfiguration cause, a new event wins over the clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || local_clr) begin
			reconfiguration_flag_code_q <= ERROR_INFO_RST[14:12];
			reconfig_trigger_q <= 1'b0;
		end else if (i_ce) begin
			reconfig_trigger_q <= reconfiguration_flag_accept;
			if (reconfiguration_flag_accept) begin
				reconfiguration_flag_code_q <= i_reconfig_cause_code;
			end else if (i_clear_flags_cmd) begin
				reconfiguration_flag_code_q <= ERROR_INFO_RST[14:12];
			end
		end
	end

	assign o_reconfig_trigger = reconfig_trigger_q;

	// line code correction port and code
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || local_clr) begin
			lcc_port_q <= 1'b0;
			lcc_code_q <= ERROR_INFO_RST[10:8];
		end else if (i_ce) begin
			if (i_line_code_corrected_set) begin
				lcc_port_q <= i_hub_enable & i_line_code_port;
				lcc_code_q <= i_line_code_correction_info;
			end else if (i_line_code_corrected_clr) begin
				lcc_port_q <= 1'b0;
				lcc_code_q <= ERROR_INFO_RST[10:8];
			end
		end
	end

	// packet receive error code and source id
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || local_clr) begin
			rx_code_q <= RX_ERR_FRAME;
			rx_sid_q <= ERROR_INFO_RST[4:0];
		end else if (i_ce) begin
			if (i_rx_error_set) begin
				rx_code_q <= rx_encode(i_rx_error_causes);
				rx_sid_q <= i_rx_error_source_id;
			end else if (i_rx_error_flag_clr) begin
				rx_code_q <= RX_ERR_FRAME;
				rx_sid_q <= ERROR_INFO_RST[4:0];
			end
		end
	end

	// assemble, bit 15 reserved zero
	always_comb begin
		err_info = '0;
		err_info[RECONFIGURATION_FLAG_CODE_LSB +: 3] = reconfiguration_flag_code_q;
		err_info[LCC_PORT_BIT] = lcc_port_q;
		err_info[LCC_CODE_LSB +: 3] = lcc_code_q;
		err_info[RX_CODE_LSB +: 3] = rx_code_q;
		err_info[RX_SID_LSB +: 5] = rx_sid_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	// registered read mux; unmapped and write-only paths read zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_q <= '0;
		end else if (i_ce) begin
			if (i_rd) begin
				rdata_q <= '0;
				if (hits(i_addr, PAGE_SIZE_SELECT_OFF)) begin
					rdata_q <= {14'h0000, page_act};
				end else if (hits(i_addr, RATE_PRESCALER_SELECT_OFF)) begin
					rdata_q <= {13'h0000, rate_act};
				end else if (hits(i_addr, TIME_PHASE_DIFFERENCE_OFF)) begin
					if (i_byte_en == LANE_HIGH) begin
						rdata_q <= {phase_hi_q, 8'h00};
					end else begin
						rdata_q <= phase_q;
					end
				end else if (hits(i_addr, STRAP_PIN_SNAPSHOT_OFF)) begin
					rdata_q <= pin_info;
				end else if (hits(i_addr, ERROR_CAUSE_INFO_OFF)) begin
					rdata_q <= err_info;
				end
			end
		end
	end

	assign o_rdata = rdata_q;

endmodule

// ==== net_host_model.sv ====
`timescale 1ns/1ps
// host on the register port: one access at a time, each strobe held up to its taking edge
module net_host_model (
	// clock
	input wire logic i_clk,
	// register port
	output logic [6:0] o_addr,
	output logic [1:0] o_byte_en,
	output logic o_rd,
	output logic o_wr,
	output logic [15:0] o_wdata,
	input wire logic [15:0] i_rdata
);
	// idle bus at time zero
	initial begin
		o_addr = 7'h00;
		o_byte_en = 2'h0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////
	// write: released lines show the inverse so stale values never look valid
	task automatic wr(input logic [6:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_byte_en <= be;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		@(negedge i_clk);
	endtask
	// read: data is registered at the taking edge, picked up once settled
	task automatic rd(input logic [6:0] a, input logic [1:0] be, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_byte_en <= be;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask
endmodule

// ==== net_config_error_status_regs_sva.sv ====
`timescale 1ns/1ps
// port checker for the configuration and error register group
module net_cfg_chk
	import net_cfg_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_byte_en,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] o_rdata,
	input wire logic i_init_source_select,
	input wire logic i_transmit_online_enable,
	input wire logic i_clock_master_node,
	input wire logic i_ack_nak_tolerance_select,
	input wire logic i_reconfig_event,
	input wire logic [2:0] i_reconfig_cause_code,
	input wire logic [3:0] i_test_select_pins_n,
	input wire logic i_test_enable_pin_n,
	input wire logic [1:0] o_page_size_field,
	input wire logic o_soft_rst,
	input wire logic o_reconfig_trigger
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [2:0] up_q;
	logic [4:0] tp;
	logic rd_w;
	logic pg_wr;
	// cycles since reset, saturating, so history from reset is never trusted
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	// decoded accesses
	assign tp = {i_test_enable_pin_n, i_test_select_pins_n};
	assign rd_w = i_rd && i_ce && i_byte_en == 2'h3;
	assign pg_wr = i_wr && i_ce && i_byte_en[0] && i_addr[6:1] == 6'h17 && i_init_source_select;
	////////////////////////////////////////////////////////////////
	a_master_phase_zero: assert property (rd_w && i_addr[6:1] == 6'h19 && i_clock_master_node && $past(i_clock_master_node) && up_q > 3'h2 |=> o_rdata == 16'h0000) else $error("clock master phase not zero");
	a_unmapped_read_zero: assert property (i_rd && i_ce && i_addr[6:1] == 6'h1e |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
	a_error_reserved_zero: assert property (i_rd && i_ce && i_addr[6:1] == 6'h1d |=> !o_rdata[15]) else $error("error bit 15 set");
	a_rate_reserved_zero: assert property (rd_w && i_addr[6:1] == 6'h18 |=> o_rdata[15:3] == 13'h0000) else $error("rate reserved set");
	a_strap_copy_match: assert property (rd_w && i_addr[6:1] == 6'h1a |=> o_rdata[15:14] == o_rdata[7:6]) else $error("strap copies differ");
	a_test_mode_bit: assert property ($stable(tp)[*4] ##0 (rd_w && i_addr[6:1] == 6'h1a && up_q == 3'h7) |=> o_rdata[8] == !(&tp)) else $error("test mode bit wrong");
	a_reconfiguration_flag_cause_taken: assert property (i_ce && i_reconfig_event && i_reconfig_cause_code == 3'h0 |=> o_reconfig_trigger) else $error("cause 000 not taken");
	a_reconfiguration_flag_cause_saved: assert property (i_ce && i_reconfig_event && !i_ack_nak_tolerance_select && i_reconfig_cause_code != 3'h0 |=> !o_reconfig_trigger) else $error("saved cause triggered");
	a_soft_rst_single: assert property (o_soft_rst |=> !o_soft_rst) else $error("soft reset longer than one cycle");
	a_online_change_rst: assert property (pg_wr && i_transmit_online_enable && i_wdata[1:0] != o_page_size_field |-> ##[1:4] o_soft_rst) else $error("no soft reset on online change");
	a_page_write_used: assert property (pg_wr && !i_transmit_online_enable |-> ##2 o_page_size_field == $past(i_wdata[1:0], 2)) else $error("written page size not used");
	// main scenarios
	c_soft_rst: cover property (o_soft_rst);
	c_trigger: cover property (o_reconfig_trigger);
	c_master_read: cover property (rd_w && i_clock_master_node);
endmodule
bind net_config_error_status_regs net_cfg_chk #(.ADDR_W(ADDR_W)) chk (.*);

// ==== test_net_config_error_status_regs.sv ====
`timescale 1ns/1ps
// register-level bench for the configuration and error register group
module test_net_config_error_status_regs
	import net_cfg_pkg::*;
;
	logic i_clk = 1'b0;
	logic rst = 1'b1;
	logic init = 1'b1, online = 1'b0, master = 1'b0, tol = 1'b0, hub = 1'b1;
	logic dir = 1'b1, lport = 1'b0;
	logic [14:0] mag = 15'h0000;
	logic [6:0] ev = 7'h00, rxc = 7'h00;
	logic [2:0] cz = 3'h0, rp_s = 3'h0;
	logic [4:0] sid = 5'h00;
	logic [1:0] ps_s = 2'h0;
	logic [17:0] pins = 18'h0001f;
	logic [6:0] addr;
	logic [1:0] be;
	logic rd, wr, srst, trig;
	logic [15:0] wdata, rdata;
	logic [1:0] pg;
	logic [2:0] rt;
	int mismatches = 0, n_compared = 0, srs = 0, trg = 0;
	// clock and pulse counters
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		srs += (srst === 1'b1);
		trg += (trig === 1'b1);
	end
	net_host_model host (.i_clk(i_clk), .o_addr(addr), .o_byte_en(be), .o_rd(rd), .o_wr(wr), .o_wdata(wdata),
		.i_rdata(rdata));
	net_config_error_status_regs dut (.i_clk(i_clk), .i_sys_rst(rst), .i_ce(1'b1), .i_addr(addr), .i_byte_en(be),
		.i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .i_init_source_select(init),
		.i_transmit_online_enable(online), .i_clock_master_node(master), .i_ack_nak_tolerance_select(tol),
		.i_hub_enable(hub), .i_soft_rst_req(ev[6]), .i_phase_direction_flag(dir), .i_phase_difference_magnitude(mag),
		.i_reconfig_event(ev[0]), .i_reconfig_cause_code(cz), .i_clear_flags_cmd(ev[3]),
		.i_line_code_corrected_set(ev[1]), .i_line_code_port(lport), .i_line_code_correction_info(cz),
		.i_line_code_corrected_clr(ev[4]), .i_rx_error_set(ev[2]), .i_rx_error_causes(rxc),
		.i_rx_error_source_id(sid), .i_rx_error_flag_clr(ev[5]), .i_page_size_strap(ps_s),
		.i_rate_prescaler_strap(rp_s), .i_byte_swap_strap_n(pins[17]), .i_wide_bus_strap(pins[16]),
		.i_op_mode_strap_n(pins[15]), .i_hub_on_strap_n(pins[14]), .i_ext_wr_strap_n(pins[13]),
		.i_ext_rd_strap_n(pins[12]), .i_line_code_bypass_strap_n(pins[11]), .i_diag_strap_n(pins[10]),
		.i_transmit_online_enable_polarity_strap(pins[9]), .i_time_prescale_strap(pins[8:7]), .i_warn_prescale_strap(pins[6:5]),
		.i_test_select_pins_n(pins[4:1]), .i_test_enable_pin_n(pins[0]), .o_page_size_field(pg),
		.o_rate_prescaler_field(rt), .o_soft_rst(srst), .o_reconfig_trigger(trig));
	////////////////////////////////////////////////////////////////
	// compare, read-and-compare, event pulse, verdict
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [1:0] b, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		host.rd(a, b, d);
		chk($sformatf("reg %h", a), e & m, d & m);
	endtask
	task automatic pulse(input int k, input logic [2:0] c, input logic [6:0] m = 7'h00, input logic [4:0] s = 5'h00,
		input logic p = 1'b0);
		@(posedge i_clk);
		ev <= 7'h01 << k;
		cz <= c;
		rxc <= m;
		sid <= s;
		lport <= p;
		@(posedge i_clk);
		ev <= 7'h00;
		@(posedge i_clk);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
	// test sequence
	initial begin
		repeat (2) @(posedge i_clk);
		rst <= 1'b0;
		rdchk(7'h2f, 2'h1, 16'hffff, 16'h0000);
		rdchk(7'h30, 2'h1, 16'hffff, 16'h0000);
		rdchk(7'h32, 2'h3, 16'hffff, 16'h8000);
		rdchk(7'h3a, 2'h3, 16'hffff, 16'h0000);
		$display("test reset done");
		host.wr(7'h2f, 2'h1, 16'hffff);
		host.wr(7'h30, 2'h1, 16'hfffd);
		rdchk(7'h2f, 2'h1, 16'hffff, 16'h0003);
		rdchk(7'h30, 2'h1, 16'hffff, 16'h0005);
		chk("active config", 16'h001d, {11'h000, pg, rt});
		@(posedge i_clk);
		init <= 1'b0;
		ps_s <= 2'h2;
		rp_s <= 3'h6;
		repeat (4) @(posedge i_clk);
		rdchk(7'h2f, 2'h1, 16'h0003, 16'h0002);
		rdchk(7'h30, 2'h1, 16'h0007, 16'h0006);
		init <= 1'b1;
		$display("test config done");
		dir <= 1'b0;
		mag <= 15'h1234;
		rdchk(7'h32, 2'h3, 16'hffff, 16'h1234);
		rdchk(7'h32, 2'h1, 16'h00ff, 16'h0034);
		mag <= 15'h5678;
		rdchk(7'h33, 2'h2, 16'hff00, 16'h1200);
		dir <= 1'b1;
		mag <= 15'h7fff;
		rdchk(7'h32, 2'h3, 16'hffff, 16'hffff);
		master <= 1'b1;
		repeat (2) @(posedge i_clk);
		rdchk(7'h32, 2'h3, 16'hffff, 16'h0000);
		master <= 1'b0;
		$display("test phase done");
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clk);
			pins <= i ? 18'h154ae : 18'h2ab5f;
			repeat (4) @(posedge i_clk);
			rdchk(7'h34, 2'h3, 16'hffff, {pins[17:11], ~(&pins[4:0]), pins[17:16], pins[10:5]});
		end
		rdchk(7'h3c, 2'h3, 16'hffff, 16'h0000);
		$display("test straps done");
		for (int k = 0; k < 7; k++) begin
			pulse(2, 3'h0, 7'h01 << k, 5'(k + 9));
			rdchk(7'h3a, 2'h3, 16'h00ff, {8'h00, 3'(k), 5'(k + 9)});
			pulse(5, 3'h0);
		end
		rdchk(7'h3a, 2'h3, 16'h00ff, 16'h0000);
		pulse(2, 3'h0, 7'h48, 5'h1f);
		host.wr(7'h3a, 2'h3, 16'h0000);
		rdchk(7'h3a, 2'h3, 16'h00ff, 16'h00ff);
		pulse(5, 3'h0);
		$display("test rx errors done");
		tol <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			pulse(0, 3'(k));
			rdchk(7'h3a, 2'h3, 16'h7000, 16'(k << 12));
			pulse(3, 3'h0);
		end
		rdchk(7'h3a, 2'h3, 16'h7000, 16'h0000);
		pulse(0, 3'h6);
		tol <= 1'b0;
		pulse(0, 3'h0);
		pulse(0, 3'h3);
		chk("trigger count", 16'h0007, 16'(trg));
		pulse(3, 3'h0);
		$display("test reconfig done");
		for (int k = 0; k < 8; k++) begin
			pulse(1, 3'(k), 7'h00, 5'h00, k[0]);
			rdchk(7'h3a, 2'h3, 16'h0f00, {4'h0, k[0], 3'(k), 8'h00});
			pulse(4, 3'h0);
		end
		rdchk(7'h3a, 2'h3, 16'h0f00, 16'h0000);
		hub <= 1'b0;
		pulse(1, 3'h3, 7'h00, 5'h00, 1'b1);
		rdchk(7'h3a, 2'h3, 16'h0f00, 16'h0300);
		pulse(4, 3'h0);
		$display("test line code done");
		host.wr(7'h2f, 2'h1, 16'h0003);
		pulse(2, 3'h0, 7'h04, 5'h11);
		online <= 1'b1;
		host.wr(7'h2f, 2'h1, 16'h0001);
		repeat (6) @(posedge i_clk);
		chk("soft reset pulses", 16'h0001, 16'(srs));
		online <= 1'b0;
		rdchk(7'h3a, 2'h3, 16'hffff, 16'h0000);
		$display("test auto soft reset done");
		wrap_up();
	end
endmodule
